/* hw/msc_sideband.sv */
// Operation
// - With select low the module takes and answers two-wire management transfers.
// - With select high all two-wire traffic is ignored so modules can share one bus.
// - An undriven select reads high, so the module comes up deselected.
// - A reset pin held low past the minimum pulse time restores every user setting to default.
// - The reset execution interval starts when the reset pin rises again.
// - At the end of the interval the interrupt is raised with data-not-ready cleared.
// - Power-up posts the completion interrupt without any reset pulse.
// - A high low-power request puts the module into its reduced-power state.
// - The presence output is grounded inside the module.
// - The open-drain interrupt is pulled low for a fault or critical status.
// - Management transfers use device address A0h.
`timescale 1ns/1ps
`default_nettype none
module msc_sideband #(
  parameter int INIT_CYC = msc_pkg::INIT_CYC
) (
  input  wire logic                        i_clk,
  input  wire logic                        i_sys_rst,
  input  wire logic                        i_module_select_n,
  input  wire logic                        i_module_reset_n,
  input  wire logic                        i_low_power_request,
  input  wire logic                        i_scl,
  input  wire logic                        i_sda,
  input  wire logic [msc_pkg::FLAG_W-2:0]  i_fault_event,
  output logic                             o_sda_out,
  output logic                             o_sda_oe,
  output logic                             o_interrupt_n_out,
  output logic                             o_interrupt_n_oe,
  output logic                             o_module_present_n,
  output logic                             o_low_power_en,
  output logic                             o_data_not_ready
);
  import msc_pkg::*;

  localparam int INIT_W = $clog2(INIT_CYC + 1);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [4:0] pins_s;
  logic       sel_n_s;
  logic       rst_pin_s;
  logic       lp_s;
  logic       scl_s;
  logic       sda_s;

  // Pins reset to idle levels, so no false bus edge follows reset; select high as if pulled up
  msc_sync #(
    .WIDTH   (5),
    .RST_VAL (SYNC_RST)
  ) u_sync (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_async   ({i_module_select_n, i_module_reset_n, i_low_power_request, i_scl, i_sda}),
    .o_sync    (pins_s)
  );

  assign sel_n_s   = pins_s[4];
  assign rst_pin_s = pins_s[3];
  assign lp_s      = pins_s[2];
  assign scl_s     = pins_s[1];
  assign sda_s     = pins_s[0];

  // ****************************************
  // Reset pin qualification and sequence
  // ****************************************
  logic [RST_CNT_W-1:0] rst_low_cnt_r;
  logic [INIT_W-1:0]    init_cnt_r;
  msc_state_t           st_r;
  logic                 dnr_r;
  logic                 done_p_r;
  logic                 rst_long;

  assign rst_long = (rst_low_cnt_r == RST_CNT_W'(RST_MIN_CYC));

  // Short glitches on the pin never reach the full reset
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || rst_pin_s) begin
      rst_low_cnt_r <= '0;
    end else if (!rst_long) begin
      rst_low_cnt_r <= RST_CNT_W'(rst_low_cnt_r + 1'h1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_r       <= MSC_S_INIT;
      init_cnt_r <= '0;
      dnr_r      <= 1'h1;
      done_p_r   <= 1'h0;
    end else begin
      done_p_r <= 1'h0;
      unique case (st_r)
        MSC_S_INIT: begin
          if (rst_long) begin
            st_r  <= MSC_S_HELD;
            dnr_r <= 1'h1;
          end else if (init_cnt_r == INIT_W'(INIT_CYC - 1)) begin
            st_r     <= MSC_S_RUN;
            dnr_r    <= 1'h0;
            done_p_r <= 1'h1;
          end else begin
            init_cnt_r <= INIT_W'(init_cnt_r + 1'h1);
          end
        end
        MSC_S_RUN: begin
          if (rst_long) begin
            st_r  <= MSC_S_HELD;
            dnr_r <= 1'h1;
          end
        end
        MSC_S_HELD: begin
          dnr_r      <= 1'h1;
          init_cnt_r <= '0;
          if (rst_pin_s) begin
            st_r <= MSC_S_INIT;
          end
        end
      endcase
    end
  end

  // ****************************************
  // Two-wire management slave
  // ****************************************
  msc_phase_t ph_r;
  logic [7:0] shift_r;
  logic [2:0] bit_r;
  logic       rw_r;
  logic       first_r;
  logic [7:0] ptr_r;
  logic       sda_oe_r;
  logic       scl_q_r;
  logic       sda_q_r;
  logic       wr_en_r;
  logic [7:0] wr_addr_r;
  logic [7:0] wr_data_r;
  logic       rd_clr_r;
  logic [7:0] rd_snap_r;
  logic [7:0] flags_r;
  logic [7:0] mask_r;
  logic [7:0] rd_byte;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;
  logic       load_now;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      scl_q_r <= 1'h1;
      sda_q_r <= 1'h1;
    end else begin
      scl_q_r <= scl_s;
      sda_q_r <= sda_s;
    end
  end

  assign scl_rise = scl_s && !scl_q_r;
  assign scl_fall = !scl_s && scl_q_r;
  assign start_c  = scl_s && scl_q_r && !sda_s && sda_q_r;
  assign stop_c   = scl_s && scl_q_r && sda_s && !sda_q_r;
  assign load_now = scl_fall && ((ph_r == MSC_P_AACK && sda_oe_r && rw_r) || ph_r == MSC_P_RNXT);
  assign rd_byte  = msc_read_byte(ptr_r, dnr_r, flags_r, mask_r);

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ph_r      <= MSC_P_IDLE;
      shift_r   <= 8'h00;
      bit_r     <= 3'h0;
      rw_r      <= 1'h0;
      first_r   <= 1'h0;
      ptr_r     <= 8'h00;
      sda_oe_r  <= 1'h0;
      wr_en_r   <= 1'h0;
      wr_addr_r <= 8'h00;
      wr_data_r <= 8'h00;
      rd_clr_r  <= 1'h0;
      rd_snap_r <= 8'h00;
    end else begin
      wr_en_r  <= 1'h0;
      rd_clr_r <= 1'h0;
      if (sel_n_s || st_r == MSC_S_HELD) begin
        ph_r     <= MSC_P_IDLE;
        sda_oe_r <= 1'h0;
      end else if (start_c) begin
        ph_r     <= MSC_P_ADDR;
        bit_r    <= 3'h0;
        sda_oe_r <= 1'h0;
      end else if (stop_c) begin
        ph_r     <= MSC_P_IDLE;
        sda_oe_r <= 1'h0;
      end else if (load_now) begin
        // Snapshot so a flag raised after the load survives the clear
        ph_r     <= MSC_P_RDAT;
        shift_r  <= rd_byte;
        sda_oe_r <= !rd_byte[7];
        bit_r    <= 3'h0;
        ptr_r    <= 8'(ptr_r + 8'h01);
        if (ptr_r == FLAG_ADDR) begin
          rd_clr_r  <= 1'h1;
          rd_snap_r <= flags_r;
        end
      end else begin
        unique case (ph_r)
          MSC_P_IDLE: begin
          end
          MSC_P_ADDR: begin
            if (scl_rise) begin
              shift_r <= {shift_r[6:0], sda_s};
              bit_r   <= 3'(bit_r + 3'h1);
              if (bit_r == 3'h7) begin
                rw_r    <= sda_s;
                first_r <= 1'h1;
                ph_r    <= (shift_r[6:0] == DEV_ADDR7) ? MSC_P_AACK : MSC_P_IDLE;
              end
            end
          end
          MSC_P_AACK,
          MSC_P_WACK: begin
            if (scl_fall) begin
              if (!sda_oe_r) begin
                sda_oe_r <= 1'h1;
              end else begin
                sda_oe_r <= 1'h0;
                bit_r    <= 3'h0;
                ph_r     <= MSC_P_WDAT;
              end
            end
          end
          MSC_P_WDAT: begin
            if (scl_rise) begin
              shift_r <= {shift_r[6:0], sda_s};
              bit_r   <= 3'(bit_r + 3'h1);
              if (bit_r == 3'h7) begin
                ph_r <= MSC_P_WACK;
                if (first_r) begin
                  ptr_r   <= {shift_r[6:0], sda_s};
                  first_r <= 1'h0;
                end else begin
                  wr_en_r   <= 1'h1;
                  wr_addr_r <= ptr_r;
                  wr_data_r <= {shift_r[6:0], sda_s};
                  ptr_r     <= 8'(ptr_r + 8'h01);
                end
              end
            end
          end
          MSC_P_RDAT: begin
            if (scl_fall) begin
              if (bit_r == 3'h7) begin
                sda_oe_r <= 1'h0;
                ph_r     <= MSC_P_RACK;
              end else begin
                bit_r    <= 3'(bit_r + 3'h1);
                shift_r  <= {shift_r[6:0], 1'h0};
                sda_oe_r <= !shift_r[6];
              end
            end
          end
          MSC_P_RACK: begin
            if (scl_rise) begin
              ph_r <= sda_s ? MSC_P_IDLE : MSC_P_RNXT;
            end
          end
          MSC_P_RNXT: begin
          end
        endcase
      end
    end
  end

  // ****************************************
  // Flags, mask and interrupt
  // ****************************************
  logic [7:0] set_vec;
  logic [7:0] clr_vec;
  logic       unmasked;
  logic       int_oe_r;
  logic       lp_r;
  logic       present_r;

  assign set_vec  = {(st_r == MSC_S_RUN) ? i_fault_event : 7'h00, done_p_r};
  assign clr_vec  = rd_clr_r ? rd_snap_r : 8'h00;
  assign unmasked = |(flags_r & ~(mask_r & MASK_USABLE));

  // Set beats clear in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || st_r == MSC_S_HELD) begin
      flags_r <= 8'h00;
    end else begin
      flags_r <= (flags_r & ~clr_vec) | set_vec;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst || st_r == MSC_S_HELD) begin
      mask_r <= MASK_RST;
    end else if (wr_en_r && wr_addr_r == MASK_ADDR) begin
      mask_r <= wr_data_r;
    end
  end

  // Completion flag is never maskable
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      int_oe_r <= 1'h0;
    end else begin
      int_oe_r <= unmasked;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      lp_r      <= 1'h0;
      present_r <= 1'h0;
    end else begin
      lp_r      <= lp_s;
      present_r <= 1'h0;
    end
  end

  assign o_sda_out          = 1'h0;
  assign o_sda_oe           = sda_oe_r;
  assign o_interrupt_n_out  = 1'h0;
  assign o_interrupt_n_oe   = int_oe_r;
  assign o_module_present_n = present_r;
  assign o_low_power_en     = lp_r;
  assign o_data_not_ready   = dnr_r;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  sequence init_ends_s;
    st_r == MSC_S_INIT && !rst_long && init_cnt_r == INIT_W'(INIT_CYC - 1);
  endsequence

  sequence done_posted_s;
    !dnr_r && done_p_r ##1 flags_r[DONE_FLAG_BIT] ##1 o_interrupt_n_oe;
  endsequence

  sel_answer_a: assert property ((ph_r == MSC_P_AACK) && scl_fall && !sda_oe_r && !sel_n_s
    && !start_c && !stop_c && st_r != MSC_S_HELD |=> o_sda_oe)
    else $error("address not acknowledged");
  desel_quiet_a: assert property (sel_n_s |=> !o_sda_oe && ph_r == MSC_P_IDLE)
    else $error("deselected module touched the bus");
  addr_match_a: assert property ((ph_r == MSC_P_ADDR) && scl_rise && bit_r == 3'h7 && !sel_n_s
    && !start_c && !stop_c && st_r != MSC_S_HELD && shift_r[6:0] != DEV_ADDR7
    |=> ph_r == MSC_P_IDLE)
    else $error("foreign address accepted");
  full_reset_a: assert property (st_r == MSC_S_HELD |=> mask_r == MASK_RST && flags_r == 8'h00)
    else $error("settings not restored");
  init_start_a: assert property (st_r == MSC_S_HELD && rst_pin_s |=> st_r == MSC_S_INIT
    && init_cnt_r == '0)
    else $error("reset interval not started on release");
  completion_post_a: assert property (init_ends_s |=> done_posted_s)
    else $error("completion not posted");
  dnr_hold_a: assert property (st_r != MSC_S_RUN |-> dnr_r)
    else $error("data-not-ready cleared early");
  low_power_a: assert property (lp_s |=> o_low_power_en)
    else $error("low power not entered");
  present_low_a: assert property (!o_module_present_n ##1 !o_module_present_n)
    else $error("presence not grounded");
  int_raise_a: assert property (unmasked |=> o_interrupt_n_oe)
    else $error("interrupt not raised");
  int_release_a: assert property (!unmasked |=> !o_interrupt_n_oe)
    else $error("interrupt held without cause");
  power_up_a: assert property ($rose(done_p_r) |-> $past(st_r) == MSC_S_INIT)
    else $error("completion outside reset interval");

endmodule : msc_sideband
`default_nettype wire

/* hw/msc_pkg.sv */
// ****************************************
// Sideband control constants
// ****************************************
package msc_pkg;

  // ****************************************
  // Timing, 25 MHz core clock
  // ****************************************
  localparam int CLK_PERIOD_NS   = 40;
  localparam int T_RESET_INIT_NS = 10000;
  localparam int RST_MIN_CYC     = (T_RESET_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CNT_W       = $clog2(RST_MIN_CYC + 1);
  localparam int T_INIT_US       = 2000;
  localparam int INIT_CYC        = (T_INIT_US * 1000) / CLK_PERIOD_NS;

  // ****************************************
  // Management interface map
  // ****************************************
  localparam logic [6:0] DEV_ADDR7     = 7'h50;
  localparam logic [7:0] STATUS_ADDR   = 8'h02;
  localparam logic [7:0] FLAG_ADDR     = 8'h03;
  localparam logic [7:0] MASK_ADDR     = 8'h64;
  localparam int         FLAG_W        = 8;
  localparam int         DNR_BIT       = 0;
  localparam int         DONE_FLAG_BIT = 0;
  localparam logic [7:0] MASK_RST      = 8'h00;
  localparam logic [7:0] MASK_USABLE   = 8'hFE;
  localparam logic [4:0] SYNC_RST      = 5'h1B;

  typedef enum logic [1:0] {
    MSC_S_INIT,
    MSC_S_RUN,
    MSC_S_HELD
  } msc_state_t;

  typedef enum logic [2:0] {
    MSC_P_IDLE,
    MSC_P_ADDR,
    MSC_P_AACK,
    MSC_P_WDAT,
    MSC_P_WACK,
    MSC_P_RDAT,
    MSC_P_RACK,
    MSC_P_RNXT
  } msc_phase_t;

  function automatic logic [7:0] msc_read_byte(input logic [7:0] addr,
                                               input logic       dnr,
                                               input logic [7:0] flags,
                                               input logic [7:0] mask);
    logic [7:0] val;
    val = 8'h00;
    if (addr == STATUS_ADDR) begin
      val[DNR_BIT] = dnr;
    end else if (addr == FLAG_ADDR) begin
      val = flags;
    end else if (addr == MASK_ADDR) begin
      val = mask;
    end
    return val;
  endfunction : msc_read_byte

endpackage : msc_pkg

/* hw/msc_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Two-flop pin synchroniser
// ****************************************
module msc_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = {WIDTH{1'h0}}
) (
  input  wire logic             i_clk,
  input  wire logic             i_sys_rst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_r;

  // First stage feeds only the second
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      meta_r <= RST_VAL;
      o_sync <= RST_VAL;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end

endmodule : msc_sync
`default_nettype wire

/* dv/msc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Host board controller, two-wire master
// ****************************************
module msc_host_model (
  input  wire logic i_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_oe
);
  int half_cyc = 6;

  initial begin
    o_scl    = 1'h1;
    o_sda_oe = 1'h0;
  end

  task automatic wait_half;
    repeat (half_cyc) @(negedge i_clk);
  endtask : wait_half

  // SDA only moves while SCL is low, one clock after the fall
  task automatic bit_xfer(input logic b, output logic r);
    @(negedge i_clk);
    o_sda_oe = ~b;
    wait_half();
    o_scl = 1'h1;
    wait_half();
    r     = i_sda;
    o_scl = 1'h0;
  endtask : bit_xfer

  // Also serves as repeated start
  task automatic start_cond;
    @(negedge i_clk);
    o_sda_oe = 1'h0;
    wait_half();
    o_scl = 1'h1;
    wait_half();
    o_sda_oe = 1'h1;
    wait_half();
    o_scl = 1'h0;
  endtask : start_cond

  task automatic stop_cond;
    @(negedge i_clk);
    o_sda_oe = 1'h1;
    wait_half();
    o_scl = 1'h1;
    wait_half();
    o_sda_oe = 1'h0;
    wait_half();
  endtask : stop_cond

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], r);
    end
    bit_xfer(1'h1, r);
    ack = ~r;
  endtask : wr_byte

  // Cause of an interrupt is only learnt by reading flags
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'h1, d[i]);
    end
    bit_xfer(last, r);
  endtask : rd_byte
endmodule : msc_host_model
`default_nettype wire

/* dv/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import msc_pkg::*;
  localparam int INIT_SIM = 20;
  logic              i_clk;
  logic              i_sys_rst;
  logic              sel_low;
  logic              module_reset_n;
  logic              low_power_request;
  logic [FLAG_W-2:0] fault_ev;
  logic              scl;
  logic              host_sda_oe;
  logic              sda_out;
  logic              sda_oe;
  logic              int_out;
  logic              int_oe;
  logic              module_present_n;
  logic              lp_en;
  logic              dnr;
  logic              ack;
  logic [7:0]        rd;
  tri1               module_select_n_pin;
  tri1               sda_line;
  tri1               interrupt_n;
  int                err_total;
  int                total_checks;

  // ****************************************
  // Board wiring with pull-ups
  // ****************************************
  assign module_select_n_pin = sel_low ? 1'h0 : 1'hz;
  assign sda_line            = host_sda_oe ? 1'h0 : 1'hz;
  assign sda_line            = sda_oe ? sda_out : 1'hz;
  assign interrupt_n         = int_oe ? int_out : 1'hz;

  msc_sideband #(.INIT_CYC(INIT_SIM)) uut (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_module_select_n(module_select_n_pin),
    .i_module_reset_n(module_reset_n), .i_low_power_request(low_power_request),
    .i_scl(scl), .i_sda(sda_line), .i_fault_event(fault_ev), .o_sda_out(sda_out),
    .o_sda_oe(sda_oe), .o_interrupt_n_out(int_out), .o_interrupt_n_oe(int_oe),
    .o_module_present_n(module_present_n), .o_low_power_en(lp_en), .o_data_not_ready(dnr));

  msc_host_model host (.i_clk(i_clk), .i_sda(sda_line), .o_scl(scl), .o_sda_oe(host_sda_oe));

  initial begin
    i_clk = 1'h0;
    forever #20 i_clk = ~i_clk;
  end

  // ****************************************
  // Bench tasks
  // ****************************************
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic reg_write(input logic [7:0] addr, input logic [7:0] data, output logic ok);
    logic a0, a1, a2;
    host.start_cond();
    host.wr_byte({DEV_ADDR7, 1'h0}, a0);
    host.wr_byte(addr, a1);
    host.wr_byte(data, a2);
    host.stop_cond();
    ok = a0 & a1 & a2;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    logic a0, a1, a2;
    host.start_cond();
    host.wr_byte({DEV_ADDR7, 1'h0}, a0);
    host.wr_byte(addr, a1);
    host.start_cond();
    host.wr_byte({DEV_ADDR7, 1'h1}, a2);
    host.rd_byte(1'h1, data);
    host.stop_cond();
    ok = a0 & a1 & a2;
  endtask : reg_read

  task automatic wait_done(input int lim);
    int n;
    n = 0;
    while (dnr !== 1'h0 && n < lim) begin
      @(negedge i_clk);
      n++;
    end
    repeat (2) @(negedge i_clk);
  endtask : wait_done

  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  // Whole run needs roughly 7.5k cycles
  initial begin
    repeat (60000) @(posedge i_clk);
    err_total++;
    $display("unexpected at %0t: run did not finish", $time);
    print_verdict();
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    i_sys_rst         = 1'h1;
    sel_low           = 1'h0;
    module_reset_n    = 1'h1;
    low_power_request = 1'h0;
    fault_ev          = '0;
    err_total         = 0;
    total_checks      = 0;
    repeat (4) @(negedge i_clk);
    i_sys_rst = 1'h0;
    @(negedge i_clk);
    check({7'h00, dnr}, 8'h01, "dnr in init");
    check({7'h00, module_present_n}, 8'h00, "present");
    check({7'h00, interrupt_n}, 8'h01, "int in init");
    wait_done(INIT_SIM + 8);
    check({7'h00, dnr}, 8'h00, "dnr after power-up");
    check({7'h00, interrupt_n}, 8'h00, "power-up int");
    reg_read(FLAG_ADDR, rd, ack);
    check({7'h00, ack}, 8'h00, "undriven select ack");
    check({7'h00, interrupt_n}, 8'h00, "int kept while deselected");
    sel_low = 1'h1;
    repeat (4) @(negedge i_clk);
    reg_read(STATUS_ADDR, rd, ack);
    check({7'h00, ack}, 8'h01, "status read ack");
    check(rd, 8'h00, "status read");
    reg_read(FLAG_ADDR, rd, ack);
    check(rd, 8'h01, "completion flag");
    repeat (3) @(negedge i_clk);
    check({7'h00, interrupt_n}, 8'h01, "int released");
    reg_read(FLAG_ADDR, rd, ack);
    check(rd, 8'h00, "flags cleared by read");
    host.start_cond();
    host.wr_byte({7'h51, 1'h0}, ack);
    host.stop_cond();
    check({7'h00, ack}, 8'h00, "foreign address ack");
    reg_write(MASK_ADDR, 8'hFE, ack);
    check({7'h00, ack}, 8'h01, "mask write ack");
    reg_read(MASK_ADDR, rd, ack);
    check({7'h00, ack}, 8'h01, "mask read ack");
    check(rd, 8'hFE, "mask readback");
    fault_ev = 7'h01;
    @(negedge i_clk);
    fault_ev = '0;
    repeat (3) @(negedge i_clk);
    check({7'h00, interrupt_n}, 8'h01, "masked fault");
    reg_write(MASK_ADDR, 8'h00, ack);
    repeat (3) @(negedge i_clk);
    check({7'h00, interrupt_n}, 8'h00, "unmasked fault");
    host.half_cyc = 12;
    reg_read(FLAG_ADDR, rd, ack);
    host.half_cyc = 6;
    check({7'h00, ack}, 8'h01, "slow read ack");
    check(rd, 8'h02, "fault flag slow read");
    repeat (3) @(negedge i_clk);
    check({7'h00, interrupt_n}, 8'h01, "fault int released");
    low_power_request = 1'h1;
    repeat (4) @(negedge i_clk);
    check({7'h00, lp_en}, 8'h01, "low power on");
    low_power_request = 1'h0;
    repeat (4) @(negedge i_clk);
    check({7'h00, lp_en}, 8'h00, "low power off");
    reg_write(MASK_ADDR, 8'hFE, ack);
    module_reset_n = 1'h0;
    repeat (RST_MIN_CYC - 100) @(negedge i_clk);
    module_reset_n = 1'h1;
    repeat (6) @(negedge i_clk);
    check({7'h00, dnr}, 8'h00, "short pulse ignored");
    reg_read(MASK_ADDR, rd, ack);
    check(rd, 8'hFE, "mask kept");
    module_reset_n = 1'h0;
    repeat (RST_MIN_CYC + 10) @(negedge i_clk);
    reg_read(STATUS_ADDR, rd, ack);
    check({7'h00, ack}, 8'h00, "bus while held");
    check({7'h00, dnr}, 8'h01, "dnr while held");
    module_reset_n = 1'h1;
    repeat (INIT_SIM) @(negedge i_clk);
    check({7'h00, dnr}, 8'h01, "dnr before interval end");
    check({7'h00, interrupt_n}, 8'h01, "no int before end");
    wait_done(12);
    check({7'h00, dnr}, 8'h00, "dnr after interval");
    check({7'h00, interrupt_n}, 8'h00, "reset completion int");
    reg_read(MASK_ADDR, rd, ack);
    check({7'h00, ack}, 8'h01, "read ack after reset");
    check(rd, 8'h00, "mask restored");
    reg_read(FLAG_ADDR, rd, ack);
    check(rd, 8'h01, "completion flag again");
    print_verdict();
  end
endmodule : tb
`default_nettype wire
